// ### brake_seq_pkg.sv
// Purpose: shared constants for the brake release sequencer
// Assumes: 50 MHz system clock, delays set in tenths of a second
// Notes:   percentages are in hundredths of a percent (1500 = 15.00 %)
package brake_seq_pkg;
  // clock and tick
  localparam int unsigned CLK_HZ            = 50_000_000;
  localparam int unsigned TICK_MS           = 100;
  localparam int unsigned TICK_CYCLES       = CLK_HZ / 1000 * TICK_MS;
  // delay settings, tenths of a second
  localparam int          DELAY_W           = 13;
  localparam logic [12:0] DELAY_MAX         = 13'h1770;
  localparam logic [12:0] PROVE_TIME_RST    = 13'h0032;
  localparam logic [12:0] RELEASE_TIME_RST  = 13'h000A;
  // percentages, hundredths
  localparam int          PCT_W             = 16;
  localparam logic [15:0] TORQUE_THR_RST    = 16'h05DC;
  // trip codes
  localparam logic [7:0]  TRIP_PROVE_FAIL   = 8'hDE;
  localparam logic [7:0]  TRIP_RELEASE_FAIL = 8'hDF;
endpackage : brake_seq_pkg

// ### brake_delay_timer.sv
// Purpose: one programmable delay counted in ticks
// Assumes: tick is a single-cycle pulse on clk_sys
// Notes:   restarts whenever start drops; expired is a level
`timescale 1ns/1ns
`default_nettype none
module brake_delay_timer #(
  parameter int W = brake_seq_pkg::DELAY_W
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic         sync_clr,
  // control
  input  wire logic         tick,
  input  wire logic         start,
  input  wire logic [W-1:0] delay,
  // status
  output logic              expired
);
  typedef struct packed {
    logic [W-1:0] count;
    logic         done;
  } tmr_s;
  tmr_s st_reg;
  tmr_s st_next;

  always_comb
  begin
    st_next = st_reg;
    if (sync_clr || !start)
    begin
      st_next.count = '0;
      st_next.done  = 1'b0;
    end
    else if (st_reg.count >= delay)
      st_next.done = 1'b1;
    else if (tick)
      st_next.count = st_reg.count + W'(1);
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign expired = st_reg.done;
endmodule : brake_delay_timer
`default_nettype wire

// ### brake_release_sequencer.sv
// Purpose: holding-brake release and apply sequencer for a speed drive
// Assumes: analogue values already scaled to hundredths of a percent
// Notes:   trip outputs are sticky until a sequencer reset, sync_clr or brake_function_enable low
`timescale 1ns/1ns
`default_nettype none
module brake_release_sequencer #(
  parameter int TICK_CYCLES = brake_seq_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        sync_clr,
  // settings
  input  wire logic        brake_function_enable,
  input  wire logic [15:0] torque_threshold_setting,
  input  wire logic [15:0] zero_speed_threshold_setting,
  input  wire logic [12:0] prove_time_setting,
  input  wire logic [12:0] reference_time_setting,
  input  wire logic [12:0] holdoff_time_setting,
  input  wire logic [12:0] release_time_setting,
  input  wire logic [12:0] start_reset_time_setting,
  input  wire logic [12:0] release_fail_time_setting,
  // drive values, same clock
  input  wire logic [15:0] active_current_value,
  input  wire logic [15:0] speed_feedback_value,
  input  wire logic        drive_trip_in,
  // control pins
  input  wire logic        run_request_in,
  input  wire logic        brake_released_in,
  // status flags
  output logic             torque_proved_flag,
  output logic             latched_run_flag,
  output logic             release_reference_flag,
  output logic             brake_release_request_flag,
  output logic             at_zero_speed_flag,
  // trips
  output logic             trip_valid,
  output logic [7:0]       trip_code
);
  localparam int TW = $clog2(TICK_CYCLES + 1);

  typedef struct packed {
    logic [2:0]    run_s;
    logic [2:0]    rel_s;
    logic [TW-1:0] tick_cnt;
    logic          tick;
    logic          run;
    logic          proved;
    logic          rel_req;
    logic          rel_ref;
    logic          zero;
    logic          trip;
    logic [7:0]    code;
    logic          run_f;
    logic          rel_f;
  } seq_s;
  seq_s st_reg;
  seq_s st_next;

  // clamp delays to the legal 0..600.0 s range
  function automatic logic [12:0] clamp(input logic [12:0] d);
    clamp = (d > brake_seq_pkg::DELAY_MAX) ? brake_seq_pkg::DELAY_MAX : d;
  endfunction : clamp

  logic run_in;
  logic rel_in;
  logic seq_clr;
  logic prove_exp;
  logic ref_exp;
  logic hold_exp;
  logic rel_exp;
  logic sr_exp;
  logic fail_exp;
  logic hold_start;
  logic tclr;

  // pin filter: change counts once stages two and three agree
  assign run_in = st_reg.run_f;
  assign rel_in = st_reg.rel_f;

  assign seq_clr = drive_trip_in || !brake_function_enable || sync_clr
                   || (hold_exp && sr_exp);
  assign hold_start = st_reg.zero && !run_in && brake_function_enable;
  assign tclr = sync_clr || !brake_function_enable;

  brake_delay_timer u_prove (
    .clk_sys(clk_sys), .reset(reset), .sync_clr(tclr), .tick(st_reg.tick),
    .start(st_reg.run && !st_reg.proved && !st_reg.trip),
    .delay(clamp(prove_time_setting)), .expired(prove_exp));
  brake_delay_timer u_release (
    .clk_sys(clk_sys), .reset(reset), .sync_clr(tclr), .tick(st_reg.tick),
    .start(st_reg.proved), .delay(clamp(release_time_setting)), .expired(rel_exp));
  brake_delay_timer u_ref (
    .clk_sys(clk_sys), .reset(reset), .sync_clr(tclr), .tick(st_reg.tick),
    .start(rel_in), .delay(clamp(reference_time_setting)), .expired(ref_exp));
  brake_delay_timer u_fail (
    .clk_sys(clk_sys), .reset(reset), .sync_clr(tclr), .tick(st_reg.tick),
    .start(st_reg.rel_req), .delay(clamp(release_fail_time_setting)),
    .expired(fail_exp));
  brake_delay_timer u_hold (
    .clk_sys(clk_sys), .reset(reset), .sync_clr(tclr), .tick(st_reg.tick),
    .start(hold_start), .delay(clamp(holdoff_time_setting)), .expired(hold_exp));
  // start reset counts after holdoff expiry
  brake_delay_timer u_sreset (
    .clk_sys(clk_sys), .reset(reset), .sync_clr(tclr), .tick(st_reg.tick),
    .start(hold_exp), .delay(clamp(start_reset_time_setting)), .expired(sr_exp));

  always_comb
  begin
    st_next = st_reg;
    st_next.run_s = {st_reg.run_s[1:0], run_request_in};
    st_next.rel_s = {st_reg.rel_s[1:0], brake_released_in};
    if (st_reg.run_s[2] == st_reg.run_s[1])
      st_next.run_f = st_reg.run_s[2];
    if (st_reg.rel_s[2] == st_reg.rel_s[1])
      st_next.rel_f = st_reg.rel_s[2];
    st_next.tick = 1'b0;
    if (32'(st_reg.tick_cnt) >= TICK_CYCLES - 1)
    begin
      st_next.tick_cnt = '0;
      st_next.tick     = 1'b1;
    end
    else
      st_next.tick_cnt = st_reg.tick_cnt + TW'(1);
    st_next.zero = brake_function_enable
                   && (speed_feedback_value < zero_speed_threshold_setting);
    if (run_in)
      st_next.run = 1'b1;
    if (st_reg.run && !prove_exp && active_current_value > torque_threshold_setting)
      st_next.proved = 1'b1;
    // release request latch
    // a one-cycle clear can leave the release timer expired with proved already low
    if (rel_exp && st_reg.proved)
      st_next.rel_req = 1'b1;
    st_next.rel_ref = ref_exp && run_in && st_reg.proved;
    if (prove_exp && !st_reg.proved && !st_reg.trip)
    begin
      st_next.trip = 1'b1;
      st_next.code = brake_seq_pkg::TRIP_PROVE_FAIL;
    end
    if (fail_exp && st_reg.rel_req && !rel_in && !st_reg.trip)
    begin
      st_next.trip = 1'b1;
      st_next.code = brake_seq_pkg::TRIP_RELEASE_FAIL;
    end
    if (seq_clr || hold_exp)
      st_next.rel_req = 1'b0;
    if (seq_clr)
    begin
      st_next.run     = 1'b0;
      st_next.proved  = 1'b0;
      st_next.rel_ref = 1'b0;
    end
    // sync clear of trips; disable also
    if (tclr)
    begin
      st_next.trip = 1'b0;
      st_next.code = '0;
      st_next.zero = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign torque_proved_flag         = st_reg.proved;
  assign latched_run_flag           = st_reg.run;
  assign release_reference_flag     = st_reg.rel_ref;
  assign brake_release_request_flag = st_reg.rel_req;
  assign at_zero_speed_flag         = st_reg.zero;
  assign trip_valid                 = st_reg.trip;
  assign trip_code                  = st_reg.code;

  property p_disable_zero;
    @(posedge clk_sys) disable iff (reset)
      !brake_function_enable |=> !latched_run_flag && !brake_release_request_flag
        && !release_reference_flag && !at_zero_speed_flag;
  endproperty
  a_disable_zero: assert property (p_disable_zero) else $error("flags set while disabled");

  property p_ref_needs_proved;
    @(posedge clk_sys) disable iff (reset)
      release_reference_flag |-> torque_proved_flag;
  endproperty
  a_ref_needs_proved: assert property (p_ref_needs_proved) else $error("ref without proved");

  property p_trip_code;
    @(posedge clk_sys) disable iff (reset)
      trip_valid |-> (trip_code == 8'hDE || trip_code == 8'hDF);
  endproperty
  a_trip_code: assert property (p_trip_code) else $error("bad trip code");

  property p_drive_trip_clears;
    @(posedge clk_sys) disable iff (reset)
      drive_trip_in |=> !brake_release_request_flag && !latched_run_flag;
  endproperty
  a_drive_trip_clears: assert property (p_drive_trip_clears) else $error("latch kept");

  property p_run_latch;
    @(posedge clk_sys) disable iff (reset)
      run_in && !seq_clr |=> latched_run_flag;
  endproperty
  a_run_latch: assert property (p_run_latch) else $error("run not latched");

  property p_req_needs_proved;
    @(posedge clk_sys) disable iff (reset)
      $rose(brake_release_request_flag) |-> $past(torque_proved_flag);
  endproperty
  a_req_needs_proved: assert property (p_req_needs_proved) else $error("req early");

  property p_zero_cmp;
    @(posedge clk_sys) disable iff (reset)
      brake_function_enable && !sync_clr
        && speed_feedback_value < zero_speed_threshold_setting |=> at_zero_speed_flag;
  endproperty
  a_zero_cmp: assert property (p_zero_cmp) else $error("zero speed missed");

  property p_sync_clr;
    @(posedge clk_sys) disable iff (reset)
      sync_clr |=> !trip_valid && !latched_run_flag && !torque_proved_flag;
  endproperty
  a_sync_clr: assert property (p_sync_clr) else $error("clear failed");

  c_proved: cover property (@(posedge clk_sys) disable iff (reset) $rose(torque_proved_flag));
  c_ref: cover property (@(posedge clk_sys) disable iff (reset) $rose(release_reference_flag));
  c_trip: cover property (@(posedge clk_sys) disable iff (reset) $rose(trip_valid));
endmodule : brake_release_sequencer
`default_nettype wire

// ### brake_far_side.sv
// Purpose: far side model: brake actuator, contact and speed loop
// Assumes: one clk_sys; the contact moves 1 ns after the edge
// Notes:   stuck holds the brake on, to provoke a release failure
`timescale 1ns/1ns
`default_nettype none
module brake_far_side (
  // clock
  input  wire logic        clk_sys,
  // from the sequencer
  input  wire logic        release_request,
  input  wire logic        latched_run,
  input  wire logic        proved,
  input  wire logic        release_reference,
  // test controls
  input  wire logic        stuck,
  input  wire logic [15:0] strength,
  input  wire logic [15:0] demand,
  // to the sequencer
  output logic             brake_released,
  output logic [15:0]      active_current,
  output logic [15:0]      speed_feedback
);
  int lag_cnt = 0;
  initial brake_released = 1'b0;
  always @(posedge clk_sys)
  begin
    lag_cnt <= (release_request != brake_released) ? lag_cnt + 1 : 0;
    if (stuck)
      brake_released <= #1 1'b0;
    else if (lag_cnt >= 3)
      brake_released <= #1 release_request;
  end
  // proving speed, then zero until reference
  always_comb
  begin
    active_current = latched_run ? strength : 16'h0000;
    speed_feedback = !proved ? (latched_run ? 16'h03E8 : 16'h0000)
                   : (release_reference ? demand : 16'h0000);
  end
endmodule : brake_far_side
`default_nettype wire

// ### brake_release_sequencer_tb.sv
// Purpose: self-checking bench for the brake release sequencer
// Assumes: tick shortened to 4 clocks; delays in tenths as set below
// Notes:   time windows come from tenth settings times the tick
`timescale 1ns/1ns
`default_nettype none
module brake_release_sequencer_tb;
  localparam int TC = 4;
  logic        clk_sys = 0, reset = 1, sync_clr = 0, brake_function_enable = 1;
  logic        run_request_in = 0, drive_trip_in = 0, stuck = 0;
  logic [15:0] torque_threshold_setting = 16'h05DC, zero_speed_threshold_setting = 16'h01F4;
  logic [15:0] strength = 16'h0BB8, demand = 16'h0000;
  logic [12:0] prove_time_setting = 13'h000A, reference_time_setting = 13'h0003;
  logic [12:0] holdoff_time_setting = 13'h0003, release_time_setting = 13'h0003;
  logic [12:0] start_reset_time_setting = 13'h0002, release_fail_time_setting = 13'h0006;
  logic [15:0] active_current_value, speed_feedback_value;
  logic        brake_released_in, torque_proved_flag, latched_run_flag, release_reference_flag;
  logic        brake_release_request_flag, at_zero_speed_flag, trip_valid;
  logic [7:0]  trip_code, lfsr = 8'h34;
  logic [7:0]  trip_exp[$] = '{8'hDE, 8'hDF, 8'hDF};
  logic [5:0]  flags;
  int          bad_count = 0, comparisons = 0, n;
  assign flags = {trip_valid, at_zero_speed_flag, brake_release_request_flag,
                  release_reference_flag, latched_run_flag, torque_proved_flag};
  brake_release_sequencer #(.TICK_CYCLES(TC)) i_brake_release_sequencer (
    .clk_sys, .reset, .sync_clr, .brake_function_enable, .torque_threshold_setting,
    .zero_speed_threshold_setting, .prove_time_setting, .reference_time_setting,
    .holdoff_time_setting, .release_time_setting, .start_reset_time_setting,
    .release_fail_time_setting, .active_current_value, .speed_feedback_value, .drive_trip_in,
    .run_request_in, .brake_released_in, .torque_proved_flag, .latched_run_flag,
    .release_reference_flag, .brake_release_request_flag, .at_zero_speed_flag, .trip_valid,
    .trip_code);
  brake_far_side i_brake_far_side (
    .clk_sys, .release_request(brake_release_request_flag), .latched_run(latched_run_flag),
    .proved(torque_proved_flag), .release_reference(release_reference_flag), .stuck,
    .strength, .demand, .brake_released(brake_released_in),
    .active_current(active_current_value), .speed_feedback(speed_feedback_value));
  initial
    forever #10 clk_sys = ~clk_sys;
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next
  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask : step
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  // bounded wait on one flag, n keeps the cycles spent
  task automatic expect_flag(input int b, input logic v, input int lim);
    n = 0;
    while (flags[b] !== v && n < lim)
    begin
      step();
      n++;
    end
    check(flags[b], v);
  endtask : expect_flag
  task automatic finish_test();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  // whole run is under 400 clocks; the 10000-clock limit leaves wide margin
  initial
  begin
    #200000;
    bad_count++;
    finish_test();
  end
  initial
  begin
    repeat (6) step();
    reset = 0;
    step();
    // motor at standstill, so only the zero speed flag is up
    check({trip_code, flags}, 16'h0010);
    run_request_in = 1;
    expect_flag(1, 1, 12);
    expect_flag(0, 1, 12);
    expect_flag(3, 1, 40);
    check(n >= 10, 1);
    expect_flag(2, 1, 60);
    check(n >= 12, 1);
    check(trip_valid, 0);
    $display("test release sequence done");
    for (int i = 0; i < 8; i++)
    begin
      lfsr = lfsr_next(lfsr);
      demand = {6'h00, lfsr, 2'h0};
      repeat (3) step();
      check(at_zero_speed_flag, demand < zero_speed_threshold_setting);
    end
    $display("test zero speed done");
    run_request_in = 0;
    demand = 16'h0000;
    expect_flag(3, 0, 60);
    check(n >= 14, 1);
    expect_flag(1, 0, 40);
    check(n >= 6, 1);
    check(flags[2:0], 0);
    $display("test stop done");
    run_request_in = 1;
    expect_flag(3, 1, 80);
    drive_trip_in = 1;
    run_request_in = 0;
    repeat (3) step();
    check(flags[3:0], 0);
    // let the filtered run pin fall before the trip goes, or run relatches
    repeat (3) step();
    drive_trip_in = 0;
    repeat (8) step();
    $display("test drive trip done");
    strength = 16'h03E8;
    run_request_in = 1;
    expect_flag(5, 1, 100);
    check(n >= 40, 1);
    check(trip_code, trip_exp.pop_front());
    run_request_in = 0;
    strength = 16'h0BB8;
    // clear held past the pin filter so the old run level cannot relatch
    sync_clr = 1;
    repeat (6) step();
    sync_clr = 0;
    step();
    check(flags, 6'h10);
    $display("test prove fail done");
    // brake never lifts, then drops later
    stuck = 1;
    run_request_in = 1;
    expect_flag(3, 1, 100);
    expect_flag(5, 1, 60);
    check(n >= 22, 1);
    check(trip_code, trip_exp.pop_front());
    run_request_in = 0;
    stuck = 0;
    sync_clr = 1;
    repeat (6) step();
    sync_clr = 0;
    repeat (10) step();
    run_request_in = 1;
    expect_flag(2, 1, 150);
    stuck = 1;
    expect_flag(5, 1, 12);
    check(trip_code, trip_exp.pop_front());
    $display("test release fail done");
    brake_function_enable = 0;
    repeat (3) step();
    check(flags, 0);
    $display("test disable done");
    finish_test();
  end
endmodule : brake_release_sequencer_tb
`default_nettype wire
